// *** sci_core.sv ***
/*
 Instruction decode and execution core with shared CPU port file,
 serial host port access and link mode register.
 Assumes prog_data reflects prog_addr within the same cycle and that
 all inputs are synchronous to ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module sci_core
    import sci_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              reset,
    input  wire logic              clk_en,
    output logic [PC_W-1:0]        prog_addr,
    input  wire logic [7:0]        prog_data,
    input  wire logic              host_req,
    input  wire logic              host_write,
    input  wire logic [3:0]        host_port,
    input  wire logic [DATA_W-1:0] host_wdata,
    output logic                   host_busy,
    output logic                   host_ack,
    output logic [DATA_W-1:0]      host_rdata,
    input  wire logic              irs_valid,
    input  wire logic [3:0]        internal_addr_nibble,
    input  wire logic [3:0]        internal_data_nibble,
    output logic [3:0]             link_mode_register,
    output logic                   three_wire_mode,
    output logic                   invalid_opcode,
    output logic [DATA_W-1:0]      accum_value
);
    sci_state_t          state_reg;
    sci_state_t          state_next;
    logic [PC_W-1:0]     pc_reg;
    logic [PC_W-1:0]     pc_next;
    logic [DATA_W-1:0]   regs [16];
    logic [DATA_W-1:0]   ports [16];
    logic [7:0]          load_hi_reg;
    logic [3:0]          load_sel_reg;
    logic [3:0]          mult_cnt_reg;
    logic                host_pend_reg;
    logic                host_wr_reg;
    logic [3:0]          host_port_reg;
    logic [DATA_W-1:0]   host_data_reg;
    logic [3:0]          opc;
    logic [3:0]          sel;
    logic [DATA_W-1:0]   xv;
    logic [DATA_W-1:0]   av;
    logic [DATA_W-1:0]   iv;
    logic                i_pos;
    logic                fetch;
    logic                wr_en;
    logic [3:0]          wr_idx;
    logic [DATA_W-1:0]   wr_val;
    logic                cpu_port_acc;
    logic                bad_op;
    logic                mult_done;
    logic                host_serve;
    logic signed [31:0]  product;

    // Offset is relative to the byte after the branch opcode
    function automatic logic [PC_W-1:0] branch_target(input logic [PC_W-1:0] pc,
                                                      input logic [DATA_W-1:0] off);
        branch_target = pc + PC_STEP + off[PC_W-1:0];
    endfunction

    assign opc       = prog_data[7:4];
    assign sel       = prog_data[3:0];
    assign xv        = regs[sel];
    assign av        = regs[ACC_IDX];
    assign iv        = regs[IDX_IDX];
    assign i_pos     = !iv[DATA_W-1] && (iv != REG_RESET);
    assign fetch     = (state_reg == ST_FETCH);
    assign mult_done = (state_reg == ST_MULT) && (mult_cnt_reg == MULT_LAST);
    assign product   = $signed(regs[M_IDX]) * $signed(regs[N_IDX]);
    assign cpu_port_acc = fetch && ((opc == OP_RDPORT) || (opc == OP_WRPORT));
    assign host_serve   = host_pend_reg && !cpu_port_acc;

    always_comb
    begin
        state_next = state_reg;
        pc_next    = pc_reg;
        wr_en      = 1'b0;
        wr_idx     = sel;
        wr_val     = xv;
        bad_op     = 1'b0;
        case (state_reg)
            ST_FETCH:
            begin
                pc_next = pc_reg + PC_STEP;
                wr_en   = 1'b1;
                case (opc)
                    OP_LOAD:
                    begin
                        wr_en      = 1'b0;
                        state_next = ST_LOAD_HI;
                    end
                    OP_CLEAR:  wr_val = REG_RESET;
                    OP_AND:
                    begin
                        wr_idx = ACC_IDX;
                        wr_val = av & xv;
                    end
                    OP_OR:
                    begin
                        wr_idx = ACC_IDX;
                        wr_val = av | xv;
                    end
                    OP_ADD:
                    begin
                        wr_idx = ACC_IDX;
                        wr_val = av + xv;
                    end
                    OP_STORE:  wr_val = av;
                    OP_SHL:    wr_val = {xv[DATA_W-2:0], 1'b0};
                    OP_SHR:    wr_val = {xv[DATA_W-1], xv[DATA_W-1:1]};
                    OP_INC:    wr_val = xv + ONE;
                    OP_DEC:    wr_val = xv - ONE;
                    OP_INV:    wr_val = ~xv;
                    OP_BPOS:
                    begin
                        wr_en = 1'b0;
                        if (i_pos)
                            pc_next = branch_target(pc_reg, xv);
                    end
                    OP_BNZ:
                    begin
                        wr_en = 1'b0;
                        if (iv != REG_RESET)
                            pc_next = branch_target(pc_reg, xv);
                    end
                    OP_RDPORT:
                    begin
                        wr_idx = ACC_IDX;
                        wr_val = ports[sel];
                    end
                    OP_WRPORT: wr_en = 1'b0;
                    OP_MULT:
                    begin
                        wr_en = 1'b0;
                        if (sel == MULT_SEL)
                            state_next = ST_MULT;
                        else
                            bad_op = 1'b1;
                    end
                    default:   wr_en = 1'b0;
                endcase
            end
            ST_LOAD_HI:
            begin
                pc_next    = pc_reg + PC_STEP;
                state_next = ST_LOAD_LO;
            end
            ST_LOAD_LO:
            begin
                pc_next    = pc_reg + PC_STEP;
                wr_en      = 1'b1;
                wr_idx     = load_sel_reg;
                wr_val     = {load_hi_reg, prog_data};
                state_next = ST_FETCH;
            end
            ST_MULT:
            begin
                if (mult_done)
                    state_next = ST_FETCH;
            end
            default: state_next = ST_FETCH;
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            state_reg      <= ST_FETCH;
            pc_reg         <= PC_RESET;
            prog_addr      <= PC_RESET;
            invalid_opcode <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg      <= state_next;
            pc_reg         <= pc_next;
            prog_addr      <= pc_next;
            invalid_opcode <= bad_op;
        end
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            load_hi_reg  <= 8'h00;
            load_sel_reg <= 4'h0;
            mult_cnt_reg <= 4'h0;
        end
        else if (clk_en)
        begin
            if (fetch)
                load_sel_reg <= sel;
            if (state_reg == ST_LOAD_HI)
                load_hi_reg <= prog_data;
            if (state_reg == ST_MULT)
                mult_cnt_reg <= mult_cnt_reg + 4'h1;
            else
                mult_cnt_reg <= 4'h0;
        end
    end

    // Product lands only at the end, so M and N stay readable meanwhile
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 16; i++)
                regs[i] <= REG_RESET;
            accum_value <= REG_RESET;
        end
        else if (clk_en)
        begin
            if (mult_done)
            begin
                regs[ACC_IDX] <= product[31:16];
                regs[M_IDX]   <= product[15:0];
                accum_value   <= product[31:16];
            end
            else if (wr_en)
            begin
                regs[wr_idx] <= wr_val;
                if (wr_idx == ACC_IDX)
                    accum_value <= wr_val;
            end
        end
    end

    // Host access runs beside the program; it can overwrite CPU values
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < 16; i++)
                ports[i] <= REG_RESET;
            host_pend_reg <= 1'b0;
            host_wr_reg   <= 1'b0;
            host_port_reg <= 4'h0;
            host_data_reg <= REG_RESET;
            host_busy     <= 1'b0;
            host_ack      <= 1'b0;
            host_rdata    <= REG_RESET;
        end
        else if (clk_en)
        begin
            host_ack <= host_serve;
            if (fetch && (opc == OP_WRPORT))
                ports[sel] <= av;
            if (host_serve)
            begin
                if (host_wr_reg)
                    ports[host_port_reg] <= host_data_reg;
                host_rdata    <= ports[host_port_reg];
                host_pend_reg <= 1'b0;
                host_busy     <= 1'b0;
            end
            else if (host_req && !host_pend_reg)
            begin
                host_pend_reg <= 1'b1;
                host_busy     <= 1'b1;
                host_wr_reg   <= host_write;
                host_port_reg <= host_port;
                host_data_reg <= host_wdata;
            end
        end
    end

    // Unused mode codes are ignored and keep the previous mode
    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            link_mode_register <= MODE_FOUR_WIRE;
            three_wire_mode    <= 1'b0;
        end
        else if (clk_en && irs_valid && (internal_addr_nibble == IRS_ADDR_MODE))
        begin
            if (internal_data_nibble == MODE_FOUR_WIRE)
            begin
                link_mode_register <= MODE_FOUR_WIRE;
                three_wire_mode    <= 1'b0;
            end
            else if (internal_data_nibble == MODE_THREE_WIRE)
            begin
                link_mode_register <= MODE_THREE_WIRE;
                three_wire_mode    <= 1'b1;
            end
        end
    end

    sequence s_load_tail;
        state_reg == ST_LOAD_HI ##1 state_reg == ST_LOAD_LO ##1 state_reg == ST_FETCH;
    endsequence

    sequence s_mult_run;
        (state_reg == ST_MULT) [*8] ##1 (state_reg == ST_MULT) [*7] ##1 fetch;
    endsequence

    load_three_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        fetch && opc == OP_LOAD |=> s_load_tail)
        else $error("load did not take three cycles");
    and_acc_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        fetch && opc == OP_AND |=> regs[ACC_IDX] == $past(av & xv))
        else $error("and result wrong");
    add_acc_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        fetch && opc == OP_ADD |=> accum_value == $past(av + xv))
        else $error("add result wrong");
    shift_right_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        fetch && opc == OP_SHR
        |=> regs[$past(sel)] == {$past(xv[DATA_W-1]), $past(xv[DATA_W-1:1])})
        else $error("arithmetic shift wrong");
    branch_pos_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        fetch && opc == OP_BPOS && i_pos |=> pc_reg == $past(branch_target(pc_reg, xv)))
        else $error("positive branch not taken");
    branch_zero_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        fetch && opc == OP_BNZ && iv == REG_RESET |=> pc_reg == $past(pc_reg) + PC_STEP)
        else $error("branch taken on zero index");
    mult_len_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        fetch && prog_data == {OP_MULT, MULT_SEL} |=> s_mult_run)
        else $error("multiply length wrong");
    mult_result_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        mult_done |=> {regs[ACC_IDX], regs[M_IDX]} == $past(product))
        else $error("multiply product wrong");
    bad_mult_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        fetch && opc == OP_MULT && sel != MULT_SEL |=> invalid_opcode && fetch)
        else $error("invalid opcode not flagged");
    cpu_priority_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        host_pend_reg && cpu_port_acc |=> !host_ack && host_pend_reg)
        else $error("host not deferred");
    host_served_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        host_pend_reg && !cpu_port_acc |=> host_ack && !host_busy)
        else $error("host access stalled");
    link_three_a: assert property (@(posedge ref_clk) disable iff (reset || !clk_en)
        irs_valid && internal_addr_nibble == IRS_ADDR_MODE
        && internal_data_nibble == MODE_THREE_WIRE |=> three_wire_mode)
        else $error("three wire mode not set");
endmodule
`default_nettype wire

// *** sci_core_tb.sv ***
/*
 Self-checking bench: runs a fixed program from a combinational ROM, then checks
 results through host port reads. Assumes the host model drives all host pins.
*/
`timescale 1ns/1ps
`default_nettype none
module sci_core_tb
    import sci_pkg::*;
;
    // Program ends in a self loop so port snapshots are stable
    localparam logic [7:0] PROG [0:63] = '{
        8'h02, 8'h12, 8'h34, 8'h03, 8'hFF, 8'hFE, 8'hF3, 8'hE0, 8'h10, 8'h32, 8'hE1,
        8'h04, 8'h00, 8'h0F, 8'h05, 8'h80, 8'h03, 8'h00, 8'hF0, 8'hFF, 8'h24, 8'hE2,
        8'h35, 8'h45, 8'hE3, 8'h75, 8'h65, 8'h85, 8'h95, 8'h95, 8'hA5, 8'h10, 8'h35,
        8'hE4, 8'hF0, 8'h06, 8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'hB6, 8'h10, 8'hC6,
        8'h81, 8'hB6, 8'h80, 8'hE5, 8'hC6, 8'h80, 8'hD0, 8'h07, 8'hFF, 8'hFF, 8'hE6,
        8'hE8, 8'hE8, 8'hE8, 8'hE8, 8'hC7, 8'h00, 8'h00, 8'h00, 8'h00};
    localparam logic [3:0]  PIDX [0:7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA};
    localparam logic [15:0] PEXP [0:7] = '{16'hFFFF, 16'hDB98, 16'h000F, 16'h0012,
                                          16'h7FFE, 16'h0000, 16'hFFFF, 16'h1234};
    localparam logic [3:0]  MADDR [0:5] = '{4'h9, 4'h9, 4'h9, 4'h9, 4'h8, 4'h9};
    localparam logic [3:0]  MDATA [0:5] = '{4'h1, 4'h0, 4'h1, 4'h5, 4'h0, 4'h0};
    localparam logic [3:0]  MEXP [0:5]  = '{4'h1, 4'h0, 4'h1, 4'h1, 4'h1, 4'h0};

    logic              ref_clk;
    logic              reset;
    logic              clk_en;
    logic [PC_W-1:0]   prog_addr;
    logic [7:0]        prog_data;
    logic              host_req;
    logic              host_write;
    logic [3:0]        host_port;
    logic [DATA_W-1:0] host_wdata;
    logic              host_busy;
    logic              host_ack;
    logic [DATA_W-1:0] host_rdata;
    logic              irs_valid;
    logic [3:0]        internal_addr_nibble;
    logic [3:0]        internal_data_nibble;
    logic [3:0]        link_mode_register;
    logic              three_wire_mode;
    logic              invalid_opcode;
    logic [DATA_W-1:0] accum_value;
    logic [DATA_W-1:0] rd;
    int                lat;
    int                n;
    int                bad_count = 0;
    int                num_checks = 0;
    int                inv_count = 0;

    assign prog_data = PROG[prog_addr[5:0]];

    sci_core dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .prog_addr(prog_addr),
        .prog_data(prog_data), .host_req(host_req), .host_write(host_write),
        .host_port(host_port), .host_wdata(host_wdata), .host_busy(host_busy),
        .host_ack(host_ack), .host_rdata(host_rdata), .irs_valid(irs_valid),
        .internal_addr_nibble(internal_addr_nibble),
        .internal_data_nibble(internal_data_nibble), .link_mode_register(link_mode_register),
        .three_wire_mode(three_wire_mode), .invalid_opcode(invalid_opcode),
        .accum_value(accum_value));

    sci_host_model host (.ref_clk(ref_clk), .host_busy(host_busy), .host_ack(host_ack),
        .host_rdata(host_rdata), .host_req(host_req), .host_write(host_write),
        .host_port(host_port), .host_wdata(host_wdata), .irs_valid(irs_valid),
        .internal_addr_nibble(internal_addr_nibble),
        .internal_data_nibble(internal_data_nibble));

    initial
        ref_clk = 1'b0;
    always #20 ref_clk = ~ref_clk;

    // Sampled mid-cycle, away from the edge that launches the pulse
    always @(negedge ref_clk)
        if (invalid_opcode === 1'b1)
            inv_count++;

    task automatic tally_and_finish;
        if (bad_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic check_val(string name, logic [DATA_W-1:0] exp, logic [DATA_W-1:0] got);
        num_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask

    task automatic check_cnt(string name, int exp, int got);
        num_checks++;
        if (got != exp)
        begin
            $display("mismatch %s expected %0d seen %0d", name, exp, got);
            bad_count++;
        end
    endtask

    // A host access that never completes ends the run at once
    task automatic host_rw(input logic w, input logic [3:0] p, input logic [DATA_W-1:0] d);
        host.port_access(w, p, d, rd, lat);
        if (lat < 0)
        begin
            $display("mismatch host_ack expected 1 seen 0");
            bad_count++;
            tally_and_finish();
        end
    endtask

    // Counts edges until the address, or the accumulator, shows the value
    task automatic wait_for(input bit on_acc, input logic [15:0] v, output int cnt);
        cnt = 0;
        while ((on_acc ? accum_value : {4'h0, prog_addr}) !== v)
        begin
            @(posedge ref_clk);
            #1;
            cnt++;
            if (cnt > 400)
            begin
                bad_count++;
                tally_and_finish();
            end
        end
    endtask

    initial
    begin
        reset = 1'b1;
        clk_en = 1'b1;
        repeat (4) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        check_val("rst_pc", 16'h0000, {4'h0, prog_addr});
        check_val("rst_acc", 16'h0000, accum_value);
        wait_for(1'b0, 16'h0003, n);
        check_cnt("load_cycles", 3, n);
        wait_for(1'b0, 16'h0006, n);
        check_cnt("load_cycles2", 3, n);
        wait_for(1'b1, 16'hFFFF, n);
        check_cnt("mult_cycles", 16, n);
        host_rw(1'b1, 4'hA, 16'h5A5A);
        check_cnt("host_write_lat", 2, lat);
        host_rw(1'b1, 4'hA, 16'h1234);
        check_val("old_port_value", 16'h5A5A, rd);
        wait_for(1'b0, 16'h0037, n);
        // Two port writes by the CPU delay the host by two cycles
        host_rw(1'b0, 4'h8, 16'h0000);
        check_cnt("cpu_priority", 4, lat);
        check_val("contended_read", 16'hFFFF, rd);
        check_cnt("invalid_pulses", 1, inv_count);
        // Snapshot only once the program sits in its final loop
        for (int i = 0; i < 8; i++)
        begin
            host_rw(1'b0, PIDX[i], 16'h0000);
            check_val("port", PEXP[i], rd);
            check_cnt("idle_latency", 2, lat);
        end
        for (int i = 0; i < 6; i++)
        begin
            host.mode_write(MADDR[i], MDATA[i]);
            #1;
            check_val("link_mode", {12'h000, MEXP[i]}, {12'h000, link_mode_register});
            check_val("three_wire", {15'h0000, MEXP[i] == 4'h1}, {15'h0000, three_wire_mode});
        end
        // A mode write while the clock enable is low must not land
        @(posedge ref_clk);
        clk_en <= 1'b0;
        host.mode_write(IRS_ADDR_MODE, MODE_THREE_WIRE);
        #1;
        check_val("frozen_mode", 16'h0000, {12'h000, link_mode_register});
        @(posedge ref_clk);
        clk_en <= 1'b1;
        tally_and_finish();
    end
endmodule
`default_nettype wire

// *** sci_host_model.sv ***
/*
 Serial host model: issues CPU port reads and writes and link mode nibble writes.
 Assumes the bench calls its tasks from one process and that all pins share ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module sci_host_model
    import sci_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              host_busy,
    input  wire logic              host_ack,
    input  wire logic [DATA_W-1:0] host_rdata,
    output logic                   host_req,
    output logic                   host_write,
    output logic [3:0]             host_port,
    output logic [DATA_W-1:0]      host_wdata,
    output logic                   irs_valid,
    output logic [3:0]             internal_addr_nibble,
    output logic [3:0]             internal_data_nibble
);
    initial
    begin
        host_req = 1'b0;
        host_write = 1'b0;
        host_port = 4'h0;
        host_wdata = 16'h0000;
        irs_valid = 1'b0;
        internal_addr_nibble = 4'h0;
        internal_data_nibble = 4'h0;
    end

    // Busy is looked at off the edge; the request drops at the edge after it is seen
    task automatic port_access(input logic w, input logic [3:0] p, input logic [DATA_W-1:0] d,
                               output logic [DATA_W-1:0] rd, output int lat);
        bit held;
        bit seen;
        held = 1'b1;
        seen = 1'b0;
        lat = -1;
        rd = 16'h0000;
        @(posedge ref_clk);
        host_req <= 1'b1;
        host_write <= w;
        host_port <= p;
        host_wdata <= d;
        for (int i = 1; i < 50; i++)
        begin
            @(posedge ref_clk);
            if (held && seen)
            begin
                held = 1'b0;
                host_req <= 1'b0;
                host_write <= ~w;
                host_port <= ~p;
                host_wdata <= ~d;
            end
            #1;
            if (host_busy === 1'b1)
                seen = 1'b1;
            if (host_ack === 1'b1)
            begin
                lat = i;
                rd = host_rdata;
                break;
            end
        end
        if (held)
            host_req <= 1'b0;
    endtask

    // Mode value travels in the data nibble under internal address 1001
    task automatic mode_write(input logic [3:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        irs_valid <= 1'b1;
        internal_addr_nibble <= a;
        internal_data_nibble <= d;
        @(posedge ref_clk);
        irs_valid <= 1'b0;
        internal_addr_nibble <= ~a;
        internal_data_nibble <= ~d;
    endtask
endmodule
`default_nettype wire

// *** sci_pkg.sv ***
/*
 Shared constants and types for the sensor CPU instruction core.
 Assumes one synchronous clock domain and byte-wide program memory.
*/
`default_nettype none
package sci_pkg;
    localparam int          DATA_W          = 16;
    localparam int          PC_W            = 12;
    localparam logic [3:0]  OP_LOAD         = 4'h0;
    localparam logic [3:0]  OP_CLEAR        = 4'h1;
    localparam logic [3:0]  OP_AND          = 4'h2;
    localparam logic [3:0]  OP_OR           = 4'h3;
    localparam logic [3:0]  OP_ADD          = 4'h4;
    localparam logic [3:0]  OP_STORE        = 4'h5;
    localparam logic [3:0]  OP_SHL          = 4'h6;
    localparam logic [3:0]  OP_SHR          = 4'h7;
    localparam logic [3:0]  OP_INC          = 4'h8;
    localparam logic [3:0]  OP_DEC          = 4'h9;
    localparam logic [3:0]  OP_INV          = 4'hA;
    localparam logic [3:0]  OP_BPOS         = 4'hB;
    localparam logic [3:0]  OP_BNZ          = 4'hC;
    localparam logic [3:0]  OP_RDPORT       = 4'hD;
    localparam logic [3:0]  OP_WRPORT       = 4'hE;
    localparam logic [3:0]  OP_MULT         = 4'hF;
    localparam logic [3:0]  MULT_SEL        = 4'h3;
    localparam logic [3:0]  ACC_IDX         = 4'h0;
    localparam logic [3:0]  IDX_IDX         = 4'h1;
    localparam logic [3:0]  M_IDX           = 4'h2;
    localparam logic [3:0]  N_IDX           = 4'h3;
    localparam logic [3:0]  MULT_LAST       = 4'hE;
    localparam logic [3:0]  IRS_ADDR_MODE   = 4'h9;
    localparam logic [3:0]  MODE_FOUR_WIRE  = 4'h0;
    localparam logic [3:0]  MODE_THREE_WIRE = 4'h1;
    localparam logic [PC_W-1:0]   PC_RESET  = 12'h000;
    localparam logic [PC_W-1:0]   PC_STEP   = 12'h001;
    localparam logic [DATA_W-1:0] REG_RESET = 16'h0000;
    localparam logic [DATA_W-1:0] ONE       = 16'h0001;

    typedef enum logic [1:0]
    {
        ST_FETCH   = 2'b00,
        ST_LOAD_HI = 2'b01,
        ST_LOAD_LO = 2'b10,
        ST_MULT    = 2'b11
    } sci_state_t;
endpackage
`default_nettype wire
